// ===== rtl/fmps_pkg.sv
`default_nettype none
package fmps_pkg;
  // ==========================================================
  // Clock and time base
  // ==========================================================
  localparam int CLK_HZ          = 25_000_000;
  localparam int MS_CYCLES       = CLK_HZ / 1000;   // One millisecond
  localparam int BROWNOUT_MS     = 30;
  localparam int SUSPEND_MS      = 6;
  localparam int SUSPEND_BURST_MS = 97;
  localparam int DISCONNECT_MS   = 28;
  localparam int RESTART_MS      = 800;
  localparam int OPP_RUN_MS      = 200;
  localparam int OPP_START_MS    = 40;
  localparam int OVP_PULSES      = 4;
  localparam int MAX_ON_NS       = 55_000;
  localparam int MAX_ON_CYCLES   = MAX_ON_NS / 40;  // Round down
  localparam int FLOOR_HZ        = 25_000;
  localparam int MAX_PERIOD_CYC  = CLK_HZ / FLOOR_HZ; // 25 kHz floor
  localparam int MIN_PERIOD_CYC  = 200;             // Frequency ceiling
  // ==========================================================
  // Mains level coding
  // ==========================================================
  localparam int LEVEL_W         = 10;
  localparam logic [9:0] BROWNIN_LEVEL    = 10'h100;
  localparam logic [9:0] BROWNOUT_LEVEL   = 10'h0E0;
  localparam logic [9:0] MAINS_HIGH_LEVEL = 10'h200;
  // ==========================================================
  // Enumerations
  // ==========================================================
  typedef enum logic [1:0] {
    MODE_QR, MODE_DCM, MODE_FR, MODE_BURST
  } fmps_mode_t;
  typedef enum logic [2:0] {
    PROT_NONE, PROT_AUXOPEN, PROT_BROWNOUT, PROT_RESTART,
    PROT_LATCH, PROT_UNDERVOLTAGE_LOCKOUT
  } fmps_prot_t;
  typedef enum {
    ST_WAIT, ST_RUN, ST_STOP
  } fmps_state_t;
endpackage
`default_nettype wire

// ===== rtl/fmps_ms_timer.sv
`timescale 1ns/1ns
`default_nettype none
module fmps_ms_timer (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        msTick,
  input  wire logic        clear,
  input  wire logic        run,
  input  wire logic [9:0]  limit,
  output logic             done
);
  logic [9:0] count_reg;
  // ==========================================================
  // Millisecond counter, saturates at the limit
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!reset_n || clear || !run) begin
      count_reg <= 10'h000;
    end else if (msTick && count_reg < limit) begin
      count_reg <= count_reg + 10'h001;
    end
  end
  assign done = run && (count_reg >= limit);
endmodule
`default_nettype wire

// ===== rtl/fmps_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Sample mains every millisecond by grounding the sense pin and reading current.
// - Switching may begin only after mains exceeds brownin.
// - Mains below brownout 30 ms unbroken flags brownout, stops switching.
// - Upward crossing of brownin or mains-high level marks positive slope.
// - After mains detect, suspend sampling 6 ms, or 97 ms in burst; the 28 ms disconnect grounds the sense pin before 97 ms ends.
// - No positive slope for 28 ms: disconnected, ground sense pin continuously.
// - Quasi-resonant: new cycle only after demagnetisation and valley; the code also starts one without them at the 25 kHz floor.
// - At maximum frequency, go discontinuous and skip valleys.
// - Frequency reduction: oscillator period down to 25 kHz, minimum peak, valleys.
// - Burst mode keeps in-burst switching at or above 25 kHz.
// - Split cycle into phases: on-time current, later aux voltage.
// - Any protection stops switching, then restart or latch.
// - Per-protection responses: wait, 800 ms safe restart, or latch.
// - Regulate supply while stopped except aux-open.
// - Mains removal clears latch or cuts short safe restart.
// - Sense above peak-limit reference ends gate drive for that cycle.
// - Sense above overpower reference runs counter; 200 ms trips time-out.
// - Start-up: 100 % cap, 40 ms; after feedback below 5 V, 150 %, 200 ms.
// - Overpower together with undervoltage lockout trips immediately.
// - Overvoltage latches after four consecutive gate pulses with condition.
// - After safe restart, resume only if mains exceeds brownin.
// - Latched off stays off while mains present.
module fmps_supervisor (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [9:0]       mainsLevel,
  input  wire logic             levelValid,
  output logic                  senseGround,
  output logic                  supplyRegulate,
  input  wire logic             supplyAboveStart,
  input  wire logic             undervoltageLockout,
  input  wire logic             auxOpen,
  input  wire logic             overTemp,
  input  wire logic             auxOverVoltage,
  input  wire logic             demagDone,
  input  wire logic             valleyDetect,
  input  wire logic             peakLimitTrip,
  input  wire logic             overpowerTimerTrip,
  input  wire logic             feedbackBelow5V,
  input  wire fmps_pkg::fmps_mode_t loadMode,
  input  wire logic [10:0]      vcoPeriod,
  output logic                  gateDrive,
  output logic                  auxCurrentPhase,
  output logic                  overpowerCap150,
  output logic                  minPeakHold,
  output logic                  brownoutFlag,
  output logic                  mainsPresent,
  output fmps_pkg::fmps_prot_t protCause
);
  import fmps_pkg::*;
  // ==========================================================
  // Millisecond tick from the single reference clock
  // ==========================================================
  logic [14:0] divCount_reg;
  logic        msTick;
  always_ff @(posedge clk) begin
    if (!reset_n || divCount_reg == 15'(MS_CYCLES - 1)) begin
      divCount_reg <= 15'h0000;
    end else begin
      divCount_reg <= divCount_reg + 15'h0001;
    end
  end
  assign msTick = (divCount_reg == 15'(MS_CYCLES - 1));
  // ==========================================================
  // Mains sampling and slope detection
  // ==========================================================
  logic [9:0]  prevLevel_reg;
  logic        aboveBrownin_reg;
  logic        slope;
  logic        sampling;
  logic        suspendRun_reg;
  logic        suspendDone;
  logic        slopeMissing;
  logic        lowTimeout;
  logic        lowRun;
  logic        sampleSeen_reg;
  // Sense pin grounded for a sample, or held while disconnected
  assign sampling = msTick && !suspendRun_reg;
  assign senseGround = sampling || slopeMissing;
  // Upward crossing of either threshold between two samples
  assign slope = levelValid && sampleSeen_reg &&
    ((prevLevel_reg < BROWNIN_LEVEL && mainsLevel >= BROWNIN_LEVEL) ||
     (prevLevel_reg < MAINS_HIGH_LEVEL &&
      mainsLevel >= MAINS_HIGH_LEVEL));
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prevLevel_reg    <= 10'h000;
      aboveBrownin_reg <= 1'b0;
      sampleSeen_reg   <= 1'b0;
    end else if (levelValid) begin
      prevLevel_reg    <= mainsLevel;
      sampleSeen_reg   <= 1'b1;
      aboveBrownin_reg <= (mainsLevel >= BROWNIN_LEVEL);
    end
  end
  // Sampling pause after mains seen; longer in burst to save power
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      suspendRun_reg <= 1'b0;
    end else if (slope) begin
      suspendRun_reg <= 1'b1;
    end else if (suspendDone) begin
      suspendRun_reg <= 1'b0;
    end
  end
  fmps_ms_timer uSuspend (
    .clk     (clk),
    .reset_n (reset_n),
    .msTick  (msTick),
    .clear   (slope),
    .run     (suspendRun_reg),
    .limit   (loadMode == MODE_BURST ? 10'(SUSPEND_BURST_MS)
                                      : 10'(SUSPEND_MS)),
    .done    (suspendDone)
  );
  // Disconnect: 28 ms without a rising slope
  fmps_ms_timer uDisconnect (
    .clk     (clk),
    .reset_n (reset_n),
    .msTick  (msTick),
    .clear   (slope),
    .run     (1'b1),
    .limit   (10'(DISCONNECT_MS)),
    .done    (slopeMissing)
  );
  assign mainsPresent = !slopeMissing;
  // Brownout: zero crossings are short, so only 30 ms unbroken counts
  assign lowRun = sampleSeen_reg && prevLevel_reg < BROWNOUT_LEVEL;
  fmps_ms_timer uBrownout (
    .clk     (clk),
    .reset_n (reset_n),
    .msTick  (msTick),
    .clear   (1'b0),
    .run     (lowRun),
    .limit   (10'(BROWNOUT_MS)),
    .done    (lowTimeout)
  );
  // ==========================================================
  // Protection state machine
  // ==========================================================
  fmps_state_t state_reg;
  fmps_prot_t  cause_reg;
  logic        restartDone;
  logic        oppTimeout;
  logic        maxOnTrip;
  logic        ovpTrip;
  logic        anyTrip;
  fmps_prot_t  tripCause;
  always_comb begin
    tripCause = PROT_NONE;
    if (overTemp || ovpTrip) begin
      tripCause = PROT_LATCH;
    end else if (oppTimeout || maxOnTrip ||
                 (overpowerTimerTrip && undervoltageLockout)) begin
      tripCause = PROT_RESTART;
    end else if (auxOpen) begin
      tripCause = PROT_AUXOPEN;
    end else if (lowTimeout) begin
      tripCause = PROT_BROWNOUT;
    end else if (undervoltageLockout) begin
      tripCause = PROT_UNDERVOLTAGE_LOCKOUT;
    end
  end
  assign anyTrip = (tripCause != PROT_NONE);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ST_WAIT;
      cause_reg <= PROT_NONE;
    end else begin
      case (state_reg)
        ST_WAIT: begin
          if (aboveBrownin_reg && supplyAboveStart && !anyTrip) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (anyTrip) begin
            state_reg <= ST_STOP;
            cause_reg <= tripCause;
          end
        end
        ST_STOP: begin
          case (cause_reg)
            PROT_AUXOPEN:  if (!auxOpen) state_reg <= ST_WAIT;
            PROT_BROWNOUT: if (aboveBrownin_reg) state_reg <= ST_WAIT;
            PROT_UNDERVOLTAGE_LOCKOUT:     if (supplyAboveStart) state_reg <= ST_WAIT;
            // Only removal of mains ends a latch or cuts restart short
            PROT_RESTART:  if (restartDone || slopeMissing)
                             state_reg <= ST_WAIT;
            PROT_LATCH:    if (slopeMissing) state_reg <= ST_WAIT;
            default:       state_reg <= ST_WAIT;
          endcase
        end
        default: state_reg <= ST_WAIT;
      endcase
    end
  end
  fmps_ms_timer uRestart (
    .clk     (clk),
    .reset_n (reset_n),
    .msTick  (msTick),
    .clear   (1'b0),
    .run     (state_reg == ST_STOP && cause_reg == PROT_RESTART),
    .limit   (10'(RESTART_MS)),
    .done    (restartDone)
  );
  assign protCause = (state_reg == ST_STOP) ? cause_reg : PROT_NONE;
  assign brownoutFlag = (protCause == PROT_BROWNOUT);
  // Supply held up from the sense pin while not running, unless aux open
  assign supplyRegulate = (state_reg != ST_RUN) &&
                          (protCause != PROT_AUXOPEN);
  // ==========================================================
  // Overpower: start-up cap and time-out length
  // ==========================================================
  logic started_reg;
  always_ff @(posedge clk) begin
    if (!reset_n || state_reg != ST_RUN) begin
      started_reg <= 1'b0;
    end else if (feedbackBelow5V) begin
      started_reg <= 1'b1;
    end
  end
  assign overpowerCap150 = started_reg;
  fmps_ms_timer uOverpower (
    .clk     (clk),
    .reset_n (reset_n),
    .msTick  (msTick),
    .clear   (1'b0),
    .run     (overpowerTimerTrip && state_reg == ST_RUN),
    .limit   (started_reg ? 10'(OPP_RUN_MS) : 10'(OPP_START_MS)),
    .done    (oppTimeout)
  );
  // ==========================================================
  // Switching cycle: on, demag, valley wait, next
  // ==========================================================
  logic [10:0] period_reg;
  logic [10:0] onCount_reg;
  logic        onPhase_reg;
  logic        demagSeen_reg;
  logic [10:0] minPeriod;
  logic        startOk;
  // Frequency reduction takes the oscillator period; other modes keep ceiling
  assign minPeriod = (loadMode == MODE_FR) ? vcoPeriod
                                           : 11'(MIN_PERIOD_CYC);
  assign startOk = (demagSeen_reg && valleyDetect && period_reg >= minPeriod)
                   || period_reg >= 11'(MAX_PERIOD_CYC);
  assign maxOnTrip = onPhase_reg && onCount_reg >= 11'(MAX_ON_CYCLES);
  always_ff @(posedge clk) begin
    if (!reset_n || state_reg != ST_RUN || anyTrip) begin
      onPhase_reg   <= 1'b0;
      onCount_reg   <= 11'h000;
      period_reg    <= 11'h000;
      demagSeen_reg <= 1'b0;
    end else if (onPhase_reg) begin
      period_reg  <= period_reg + 11'h001;
      onCount_reg <= onCount_reg + 11'h001;
      if (peakLimitTrip) begin
        onPhase_reg <= 1'b0;
      end
    end else begin
      if (period_reg != 11'h7FF) begin
        period_reg <= period_reg + 11'h001;
      end
      if (demagDone) begin
        demagSeen_reg <= 1'b1;
      end
      if (startOk || period_reg == 11'h000) begin
        onPhase_reg   <= 1'b1;
        onCount_reg   <= 11'h000;
        period_reg    <= 11'h000;
        demagSeen_reg <= 1'b0;
      end
    end
  end
  assign gateDrive = onPhase_reg && !peakLimitTrip;
  assign auxCurrentPhase = onPhase_reg;
  assign minPeakHold = (loadMode == MODE_FR);
  // ==========================================================
  // Overvoltage: four gate pulses in a row
  // ==========================================================
  logic [2:0] ovpCount_reg;
  logic       onPrev_reg;
  always_ff @(posedge clk) begin
    if (!reset_n || state_reg != ST_RUN) begin
      ovpCount_reg <= 3'h0;
      onPrev_reg   <= 1'b0;
    end else begin
      onPrev_reg <= onPhase_reg;
      if (!onPhase_reg && demagSeen_reg == 1'b0 && onPrev_reg) begin
        if (auxOverVoltage) begin
          ovpCount_reg <= ovpCount_reg + 3'h1;
        end else begin
          ovpCount_reg <= 3'h0;
        end
      end
    end
  end
  assign ovpTrip = (ovpCount_reg == 3'(OVP_PULSES));
  // ==========================================================
  // Checks
  // ==========================================================
  a_gate_stopped: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg != ST_RUN |-> !gateDrive)
    else $error("gate active while stopped");
  a_peak_limit: assert property (@(posedge clk) disable iff (!reset_n)
    peakLimitTrip |-> !gateDrive ##1 !gateDrive)
    else $error("gate not ended by peak limit");
  a_disconnect_ground: assert property (@(posedge clk)
    disable iff (!reset_n) slopeMissing |-> senseGround)
    else $error("sense pin not grounded");
  a_start_brownin: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(state_reg == ST_RUN) |-> $past(aboveBrownin_reg))
    else $error("start without brownin");
  a_latch_held: assert property (@(posedge clk) disable iff (!reset_n)
    (protCause == PROT_LATCH && !slopeMissing) |=> state_reg == ST_STOP)
    else $error("latch left with mains present");
  a_ovp_latch: assert property (@(posedge clk) disable iff (!reset_n)
    (ovpTrip && state_reg == ST_RUN) |=> protCause == PROT_LATCH)
    else $error("overvoltage not latched");
  a_opp_undervoltage_lockout: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == ST_RUN && overpowerTimerTrip && undervoltageLockout
     && !overTemp && !ovpTrip) |=> protCause == PROT_RESTART)
    else $error("overpower with lockout missed");
  a_regulate_aux: assert property (@(posedge clk) disable iff (!reset_n)
    protCause == PROT_AUXOPEN |-> !supplyRegulate)
    else $error("regulating with aux open");
  a_max_on: assert property (@(posedge clk) disable iff (!reset_n)
    (maxOnTrip && state_reg == ST_RUN && !overTemp && !ovpTrip)
    |=> protCause == PROT_RESTART)
    else $error("max on-time not handled");
  c_run: cover property (@(posedge clk) state_reg == ST_RUN);
  c_latch: cover property (@(posedge clk) protCause == PROT_LATCH);
  c_restart: cover property (@(posedge clk) $fell(restartDone));
  c_slope: cover property (@(posedge clk) slope);
endmodule
`default_nettype wire

// ===== tb/fmps_stage_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Power stage, auxiliary winding and mains
// ==========================================
module fmps_stage_model #(
  parameter int ON_LEN    = 40,
  parameter int DEMAG_LEN = 60,
  parameter int RING_LEN  = 40
) (
  input  wire logic       clk,
  input  wire logic       gateDrive,
  input  wire logic       senseGround,
  input  wire logic [9:0] mainsCode,
  output logic [9:0]      mainsLevel,
  output logic            levelValid,
  output logic            demagDone,
  output logic            valleyDetect,
  output logic            peakLimitTrip
);
  logic gatePrev = 1'b0;
  int   sinceRise = 1000;
  int   offCnt = 1000;

  // Quiet lines at time zero
  initial begin
    mainsLevel = 10'h000;
    levelValid = 1'b0;
    demagDone = 1'b0;
    valleyDetect = 1'b0;
    peakLimitTrip = 1'b0;
  end

  // Pin current only means something while grounded; else it wanders
  always @(negedge clk) begin
    levelValid <= senseGround;
    mainsLevel <= senseGround ? mainsCode : ~mainsLevel;
  end

  // Current ramp trips the peak limit; ringing gives a valley train
  always @(negedge clk) begin
    gatePrev <= gateDrive;
    sinceRise <= (gateDrive && !gatePrev) ? 1 : sinceRise + 1;
    offCnt <= gateDrive ? 0 : offCnt + 1;
    peakLimitTrip <= sinceRise >= ON_LEN - 1 && sinceRise < ON_LEN + 2;
    demagDone <= !gateDrive && offCnt >= DEMAG_LEN;
    valleyDetect <= !gateDrive && offCnt >= DEMAG_LEN &&
                    (offCnt - DEMAG_LEN) % RING_LEN == 0;
  end
endmodule
`default_nettype wire

// ===== tb/tb_flyback_mode_protection_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  mismatches++; $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); \
  end end
module tb_flyback_mode_protection_supervisor;
  import fmps_pkg::*;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       levelValid, senseGround, supplyRegulate, gateDrive;
  logic       supplyAboveStart, undervoltageLockout, auxOpen, overTemp;
  logic       auxOverVoltage, demagDone, valleyDetect, peakLimitTrip;
  logic       overpowerTimerTrip, feedbackBelow5V, auxCurrentPhase;
  logic       overpowerCap150, minPeakHold, brownoutFlag, mainsPresent;
  logic [9:0] mainsLevel, mainsCode;
  logic [10:0] vcoPeriod;
  fmps_mode_t loadMode;
  fmps_prot_t protCause;
  int         mismatches = 0;
  int         total_checks = 0;
  int         cycles = 0;
  logic       needValley = 1'b0;
  logic       gatePrev = 1'b0;

  fmps_supervisor dut (.clk(clk), .reset_n(reset_n),
    .mainsLevel(mainsLevel), .levelValid(levelValid),
    .senseGround(senseGround), .supplyRegulate(supplyRegulate),
    .supplyAboveStart(supplyAboveStart),
    .undervoltageLockout(undervoltageLockout), .auxOpen(auxOpen),
    .overTemp(overTemp), .auxOverVoltage(auxOverVoltage),
    .demagDone(demagDone), .valleyDetect(valleyDetect),
    .peakLimitTrip(peakLimitTrip),
    .overpowerTimerTrip(overpowerTimerTrip),
    .feedbackBelow5V(feedbackBelow5V), .loadMode(loadMode),
    .vcoPeriod(vcoPeriod), .gateDrive(gateDrive),
    .auxCurrentPhase(auxCurrentPhase),
    .overpowerCap150(overpowerCap150), .minPeakHold(minPeakHold),
    .brownoutFlag(brownoutFlag), .mainsPresent(mainsPresent),
    .protCause(protCause));

  fmps_stage_model stage (.clk(clk), .gateDrive(gateDrive),
    .senseGround(senseGround), .mainsCode(mainsCode),
    .mainsLevel(mainsLevel), .levelValid(levelValid),
    .demagDone(demagDone), .valleyDetect(valleyDetect),
    .peakLimitTrip(peakLimitTrip));

  // ==========================================
  // Clock, hang guard and verdict
  // ==========================================
  always #20 clk = ~clk;

  // Generous ceiling: the run needs about three mains samples
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done();
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchers on every cycle of the switching stream
  always @(negedge clk) begin
    if (reset_n === 1'b1) begin
      if (gateDrive === 1'b1 && gatePrev === 1'b0) `CHK(needValley, 1'b0)
      if (peakLimitTrip === 1'b1) `CHK(gateDrive, 1'b0)
      if (gateDrive === 1'b1) `CHK(auxCurrentPhase, 1'b1)
    end
    // A start from standstill needs no valley
    if (gatePrev === 1'b1 && gateDrive === 1'b0) needValley <= 1'b1;
    else if (valleyDetect === 1'b1 || supplyRegulate === 1'b1)
      needValley <= 1'b0;
    gatePrev <= gateDrive;
  end

  // ==========================================
  // Helpers
  // ==========================================
  task automatic wait_sense(input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (senseGround !== 1'b1 && n < lim);
  endtask

  // Counts cycles to a rising or falling gate edge, capped at lim
  task automatic wait_gate(input logic lvl, input int lim, output int n);
    logic was;
    was = lvl;
    n = 0;
    while (n < lim) begin
      @(negedge clk);
      n++;
      if (gateDrive === lvl && was !== lvl) break;
      was = gateDrive;
    end
  endtask

  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_reset();
    reset_n = 1'b0;
    repeat (8) @(negedge clk);
    `CHK(gateDrive, 1'b0)
    `CHK(protCause, PROT_NONE)
    `CHK(supplyRegulate, 1'b1)
    reset_n = 1'b1;
    @(negedge clk);
    `CHK(senseGround, 1'b0)
  endtask

  // Low sample holds off; exactly one ms later a high one starts it
  task automatic t_brownin();
    int n;
    mainsCode = 10'h080;
    wait_sense(MS_CYCLES + 10, n);
    `CHK(n <= MS_CYCLES + 2, 1'b1)
    @(negedge clk);
    `CHK(senseGround, 1'b0)
    wait_gate(1'b1, 300, n);
    `CHK(n, 300)
    mainsCode = 10'h180;
    wait_sense(MS_CYCLES, n);
    `CHK(n, MS_CYCLES - 301)
    wait_gate(1'b1, 20, n);
    `CHK(n < 20, 1'b1)
    `CHK(overpowerCap150, 1'b0)
    feedbackBelow5V = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(overpowerCap150, 1'b1)
  endtask

  // Stage rings fast, so the frequency ceiling forces valley skips
  task automatic t_modes();
    int n;
    int minP;
    for (int m = 0; m < 4; m++) begin
      loadMode = fmps_mode_t'(m);
      wait_gate(1'b1, 3000, n);
      wait_gate(1'b1, 3000, n);
      minP = (loadMode == MODE_FR) ? int'(vcoPeriod) : MIN_PERIOD_CYC;
      `CHK(n >= minP && n <= MAX_PERIOD_CYC, 1'b1)
      `CHK(minPeakHold, loadMode == MODE_FR)
    end
  endtask

  task automatic t_waits();
    int n;
    auxOpen = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(protCause, PROT_AUXOPEN)
    `CHK(supplyRegulate, 1'b0)
    `CHK(gateDrive, 1'b0)
    auxOpen = 1'b0;
    wait_gate(1'b1, 2000, n);
    `CHK(n < 2000, 1'b1)
    `CHK(protCause, PROT_NONE)
    undervoltageLockout = 1'b1;
    supplyAboveStart = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(protCause, PROT_UNDERVOLTAGE_LOCKOUT)
    `CHK(supplyRegulate, 1'b1)
    undervoltageLockout = 1'b0;
    supplyAboveStart = 1'b1;
    wait_gate(1'b1, 2000, n);
    `CHK(n < 2000, 1'b1)
  endtask

  // Counter is near empty, yet the pair trips at once
  task automatic t_restart();
    int n;
    overpowerTimerTrip = 1'b1;
    undervoltageLockout = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(protCause, PROT_RESTART)
    `CHK(supplyRegulate, 1'b1)
    `CHK(brownoutFlag, 1'b0)
    `CHK(mainsPresent, 1'b1)
    overpowerTimerTrip = 1'b0;
    undervoltageLockout = 1'b0;
    wait_gate(1'b1, 1000, n);
    `CHK(n, 1000)
    `CHK(protCause, PROT_RESTART)
  endtask

  task automatic t_ovp();
    int n;
    t_reset();
    wait_sense(MS_CYCLES + 10, n);
    wait_gate(1'b1, 20, n);
    `CHK(n < 20, 1'b1)
    // Overvoltage stands from the first stroke, so four pulses count
    auxOverVoltage = 1'b1;
    for (int i = 1; i <= 4; i++) begin
      wait_gate(1'b0, 3000, n);
      repeat (3) @(negedge clk);
      `CHK(protCause, (i == 4) ? PROT_LATCH : PROT_NONE)
    end
    wait_gate(1'b1, 1000, n);
    `CHK(n, 1000)
    `CHK(supplyRegulate, 1'b1)
  endtask

  // Inputs settled at time zero, then the sequence
  initial begin
    supplyAboveStart = 1'b1;
    undervoltageLockout = 1'b0;
    auxOpen = 1'b0;
    overTemp = 1'b0;
    auxOverVoltage = 1'b0;
    overpowerTimerTrip = 1'b0;
    feedbackBelow5V = 1'b0;
    loadMode = MODE_QR;
    vcoPeriod = 11'h12C;
    mainsCode = 10'h080;
    t_reset();
    t_brownin();
    t_modes();
    t_waits();
    t_restart();
    t_ovp();
    test_done();
  end
endmodule
`default_nettype wire
